// ### ifc_core_model.sv
module ifc_core_model
    import ifc_pkg::*;
#(
    parameter ifc_ctx_t CTX = '0
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] cmd,
    input  wire logic       vector_go,
    input  wire logic       restore_go,
    input  wire ifc_ctx_t   restore_ctx,
    output logic            core_boundary,
    output logic [14:0]     core_ret_pc,
    output ifc_ctx_t        core_ctx,
    output logic            core_push,
    output logic [14:0]     core_push_pc,
    output logic            core_pop,
    output logic            core_retfie,
    output logic            core_sleep
);
    assign core_boundary = 1'b1;
    assign core_ret_pc   = 15'h1234;
    assign core_push_pc  = 15'h4abc;
    assign core_retfie   = (cmd == 3'h1);
    assign core_push     = (cmd == 3'h2);
    assign core_pop      = (cmd == 3'h3);
    assign core_sleep    = (cmd == 3'h4);
    always_ff @(posedge clk) begin
        if (rst) begin
            core_ctx <= CTX;
        end else if (restore_go) begin
            core_ctx <= restore_ctx;
            // timeout and powerdown stay live, the copy never carries them
            core_ctx.status[4:3] <= core_ctx.status[4:3];
        end else if (vector_go) begin
            // the routine scribbles on live state that the return must undo
            core_ctx.w      <= ~core_ctx.w;
            core_ctx.pc_high_latch <= ~core_ctx.pc_high_latch;
        end
    end
endmodule

// ### ifc_pkg.sv
package ifc_pkg;

    // register byte addresses, one aligned 32-bit word each
    localparam logic [11:0] OFS_CTRL        = 12'h700;
    localparam logic [11:0] OFS_PERIPH_FLG0 = 12'h704;
    localparam logic [11:0] OFS_PWR_STATUS  = 12'h708;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h70c;
    localparam logic [11:0] OFS_TMR_FLG4    = 12'h710;
    localparam logic [11:0] OFS_IRQ_MASK    = 12'h714;
    localparam logic [11:0] OFS_CORE_STATE  = 12'h718;
    // shadow copies, bank 63 window
    localparam logic [11:0] OFS_SHD_W       = 12'h7e0;
    localparam logic [11:0] OFS_SHD_STATUS  = 12'h7e4;
    localparam logic [11:0] OFS_SHD_BSR     = 12'h7e8;
    localparam logic [11:0] OFS_SHD_FSR0    = 12'h7ec;
    localparam logic [11:0] OFS_SHD_FSR1    = 12'h7f0;
    localparam logic [11:0] OFS_SHD_PC_HIGH_LATCH  = 12'h7f4;

    // control register fields
    localparam int CTRL_GIE_BIT      = 0;
    localparam int CTRL_EXT_EN_BIT   = 1;
    localparam int CTRL_IDLE_SEL_BIT = 2;
    localparam int CTRL_ROI_BIT      = 3;
    localparam int CTRL_DOZE_BIT     = 4;
    localparam int CTRL_STK_RST_BIT  = 5;
    localparam int CTRL_EDGE_UP_BIT  = 6;
    localparam logic [7:0] CTRL_RESET = 8'h40;

    // flag registers
    localparam int PF0_EXT_BIT       = 0;
    localparam logic [7:0] PF0_MASK  = 8'h01;
    localparam logic [7:0] TFLG_MASK = 8'h3f;
    localparam int PWR_OVF_BIT       = 7;
    localparam int PWR_UNF_BIT       = 6;
    localparam logic [7:0] PWR_MASK  = 8'hc0;

    // sticky event bits of the irq status and mask registers
    localparam int EV_EXT_BIT   = 0;
    localparam int EV_TMR_BIT   = 1;
    localparam int EV_OVF_BIT   = 2;
    localparam int EV_UNF_BIT   = 3;
    localparam int EV_ENTRY_BIT = 4;
    localparam logic [7:0] EV_MASK = 8'h1f;

    // live status bits that are not part of the saved context
    localparam int STATUS_TIMEOUT_BIT   = 4;
    localparam int STATUS_POWERDOWN_BIT = 3;

    localparam int STACK_DEPTH_DEF = 16;
    localparam int PC_W_DEF        = 15;

    typedef struct packed {
        logic [7:0]  w;
        logic [7:0]  status;
        logic [7:0]  bank_selector;
        logic [15:0] fsr0;
        logic [15:0] fsr1;
        logic [7:0]  pc_high_latch;
    } ifc_ctx_t;

    // timers 1,3,5 -> odd_ovf[0..2]; timers 2,4,6 -> even_*[0..2]
    typedef struct packed {
        logic [2:0] odd_ovf;
        logic [2:0] even_match;
        logic [2:0] even_post_ovf;
        logic [2:0] even_1to1;
    } ifc_tmr_ev_t;

endpackage

// ### ifc_sva.sv
module ifc_sva
    import ifc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire ifc_tmr_ev_t tmr_ev,
    input wire logic        core_retfie,
    input wire logic        core_sleep,
    input wire logic        vector_go,
    input wire logic        restore_go,
    input wire logic        soft_reset,
    input wire logic        idle_active,
    input wire logic        sleep_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // the acknowledge is a single low cycle, then the slave stalls again
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer: assert property (s_req |=> s_ack) else $error("bus answer missing");
    a_vector_single: assert property (vector_go |=> !vector_go) else $error("vector pulse too long");
    a_restore_cause: assert property (restore_go |-> $past(core_retfie)) else $error("restore without return");
    a_restore_single: assert property (restore_go |=> !restore_go) else $error("restore pulse too long");
    a_sreset_pulse: assert property (soft_reset |=> !soft_reset) else $error("soft reset too long");
    a_idle_wake: assert property (idle_active && (|tmr_ev.odd_ovf) |-> ##[1:2] !idle_active)
        else $error("idle not ended by event");
    a_mode_excl: assert property (!(idle_active && sleep_active)) else $error("idle and sleep together");
    a_sleep_enter: assert property (core_sleep && !idle_active && !sleep_active |=> idle_active || sleep_active)
        else $error("sleep not entered");
endmodule
bind ifc_top ifc_sva ifc_sva_i (
    .clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .tmr_ev, .core_retfie, .core_sleep,
    .vector_go, .restore_go, .soft_reset, .idle_active, .sleep_active
);

// ### ifc_top.sv
// Functional notes
// - ext pin edge sets flag regardless of enables
// - flag with both enables vectors the core
// - entry pushes return pc onto stack
// - entry saves core context except timeout, powerdown
// - return restores context from shadow copies
// - shadows read/write by software, restored on return
// - timer flags bits 0-5, reset zero, top unimplemented
// - even timers: postscaler overflow or 1:1 match
// - odd timers: counter overflow sets flag
// - ext pin edge or timer event ends idle, select kept
// - recover-on-irq with doze restores full speed on wake from idle
// - 16x15 stack, overflow/underflow flags set
// - stack error reset enable triggers software reset
//
// Our own choice: the Avalon-MM register port.
module ifc_top
    import ifc_pkg::*;
#(
    parameter int STACK_DEPTH = STACK_DEPTH_DEF,
    parameter int PC_W        = PC_W_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [11:0]       avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq,
    input  wire logic              ext_int_pin,
    input  wire ifc_tmr_ev_t       tmr_ev,
    input  wire logic              core_boundary,
    input  wire logic [PC_W-1:0]   core_ret_pc,
    input  wire ifc_ctx_t          core_ctx,
    input  wire logic              core_push,
    input  wire logic [PC_W-1:0]   core_push_pc,
    input  wire logic              core_pop,
    input  wire logic              core_retfie,
    input  wire logic              core_sleep,
    output logic                   vector_go,
    output logic                   restore_go,
    output ifc_ctx_t               restore_ctx,
    output logic [PC_W-1:0]        pop_pc,
    output logic                   soft_reset,
    output logic                   idle_active,
    output logic                   sleep_active,
    output logic                   doze_active
);

    localparam int PTR_W = $clog2(STACK_DEPTH + 1);
    localparam int IDX_W = $clog2(STACK_DEPTH);
    localparam logic [7:0] STATUS_SAVE_MASK =
        ~((8'h01 << STATUS_TIMEOUT_BIT) | (8'h01 << STATUS_POWERDOWN_BIT));

    generate
        if (STACK_DEPTH < 2 || (1 << IDX_W) != STACK_DEPTH || PC_W < 1 || PC_W > 16) begin : g_bad_param
            $error("ifc_top: stack depth must be a power of two, pc width 1..16");
        end
    endgenerate

    typedef struct packed {
        logic [2:0]                         sync;
        logic                               ext_lvl;
        logic                               ack;
        logic                               waitreq;
        logic [31:0]                        rdata;
        logic [7:0]                         ctrl;
        logic [7:0]                         pflags0;
        logic [7:0]                         tflags;
        logic [7:0]                         pwr;
        logic [7:0]                         ev;
        logic [7:0]                         mask;
        ifc_ctx_t                           shadow;
        logic [STACK_DEPTH-1:0][PC_W-1:0]   stack;
        logic [PTR_W-1:0]                   sp;
        logic [PC_W-1:0]                    pop_pc;
        logic                               in_isr;
        logic                               vector_go;
        logic                               restore_go;
        logic                               soft_reset;
        logic                               idle;
        logic                               asleep;
        logic                               irq;
    } ifc_state_t;

    ifc_state_t state_reg;
    ifc_state_t state_next;

    // software write, then hardware sets on top so a set survives a clear
    function automatic logic [7:0] flag_update(
        input logic [7:0] old_val,
        input logic [7:0] wr_val,
        input logic       wr_en,
        input logic [7:0] set_val,
        input logic [7:0] impl_mask
    );
        return ((wr_en ? wr_val : old_val) | set_val) & impl_mask;
    endfunction

    logic             lvl_now;
    logic             ext_edge;
    logic [5:0]       tmr_set;
    logic             wr_hit;
    logic             rd_hit;
    logic [7:0]       wbyte;
    logic             entry;
    logic             ovf_set;
    logic             unf_set;
    logic             wake_event;
    logic [7:0]       ev_set;
    logic [7:0]       ev_clear;

    always_comb begin
        state_next = state_reg;
        state_next.vector_go  = 1'b0;
        state_next.restore_go = 1'b0;
        state_next.soft_reset = 1'b0;
        ovf_set = 1'b0;
        unf_set = 1'b0;
        wbyte   = avs_writedata[7:0];

        // three-stage synchroniser; a level counts once stages two and three agree
        state_next.sync = {state_reg.sync[1], state_reg.sync[0], ext_int_pin};
        lvl_now = (state_reg.sync[1] == state_reg.sync[2]) ? state_reg.sync[2] : state_reg.ext_lvl;
        state_next.ext_lvl = lvl_now;
        ext_edge = state_reg.ctrl[CTRL_EDGE_UP_BIT] ? (lvl_now & ~state_reg.ext_lvl)
                                                    : (~lvl_now & state_reg.ext_lvl);

        for (int i = 0; i < 3; i++) begin
            tmr_set[2*i]   = tmr_ev.odd_ovf[i];
            tmr_set[2*i+1] = tmr_ev.even_1to1[i] ? tmr_ev.even_match[i] : tmr_ev.even_post_ovf[i];
        end

        // bus: one wait cycle, write and read-clear act on the acknowledge edge
        wr_hit = state_reg.ack & avs_write;
        rd_hit = state_reg.ack & avs_read;
        state_next.ack     = (avs_read | avs_write) & ~state_reg.ack;
        state_next.waitreq = ~state_next.ack;

        if (wr_hit && avs_address == OFS_CTRL) begin
            state_next.ctrl = wbyte;
        end
        if (wr_hit && avs_address == OFS_IRQ_MASK) begin
            state_next.mask = wbyte & EV_MASK;
        end
        if (wr_hit && avs_address == OFS_SHD_W) begin
            state_next.shadow.w = wbyte;
        end
        if (wr_hit && avs_address == OFS_SHD_STATUS) begin
            state_next.shadow.status = wbyte & STATUS_SAVE_MASK;
        end
        if (wr_hit && avs_address == OFS_SHD_BSR) begin
            state_next.shadow.bank_selector = wbyte;
        end
        if (wr_hit && avs_address == OFS_SHD_FSR0) begin
            state_next.shadow.fsr0 = avs_writedata[15:0];
        end
        if (wr_hit && avs_address == OFS_SHD_FSR1) begin
            state_next.shadow.fsr1 = avs_writedata[15:0];
        end
        if (wr_hit && avs_address == OFS_SHD_PC_HIGH_LATCH) begin
            state_next.shadow.pc_high_latch = wbyte;
        end

        state_next.pflags0 = flag_update(state_reg.pflags0, wbyte,
                                         wr_hit && avs_address == OFS_PERIPH_FLG0,
                                         8'(ext_edge) << PF0_EXT_BIT, PF0_MASK);
        state_next.tflags = flag_update(state_reg.tflags, wbyte,
                                        wr_hit && avs_address == OFS_TMR_FLG4,
                                        {2'b00, tmr_set}, TFLG_MASK);

        // interrupt entry only at an instruction boundary and not nested
        entry = state_reg.pflags0[PF0_EXT_BIT] & state_reg.ctrl[CTRL_GIE_BIT]
              & state_reg.ctrl[CTRL_EXT_EN_BIT] & ~state_reg.in_isr & core_boundary;
        if (entry) begin
            state_next.vector_go = 1'b1;
            state_next.in_isr    = 1'b1;
            state_next.shadow    = core_ctx;
            state_next.shadow.status = core_ctx.status & STATUS_SAVE_MASK;
        end

        // a push that finds the stack full is dropped, keeping older entries intact
        if (entry || core_push) begin
            if (state_reg.sp == PTR_W'(STACK_DEPTH)) begin
                ovf_set = 1'b1;
            end else begin
                state_next.stack[state_reg.sp[IDX_W-1:0]] = entry ? core_ret_pc : core_push_pc;
                state_next.sp = state_reg.sp + PTR_W'(1);
            end
        end else if (core_pop || (core_retfie && state_reg.in_isr)) begin
            if (state_reg.sp == '0) begin
                unf_set = 1'b1;
                state_next.pop_pc = '0;
            end else begin
                state_next.pop_pc = state_reg.stack[IDX_W'(state_reg.sp - PTR_W'(1))];
                state_next.sp = state_reg.sp - PTR_W'(1);
            end
        end

        // restore_ctx is the shadow itself, so software edits made in the isr win
        if (core_retfie && state_reg.in_isr && !entry && !core_push) begin
            state_next.restore_go = 1'b1;
            state_next.in_isr     = 1'b0;
        end

        state_next.pwr = flag_update(state_reg.pwr, wbyte,
                                     wr_hit && avs_address == OFS_PWR_STATUS,
                                     (8'(ovf_set) << PWR_OVF_BIT) | (8'(unf_set) << PWR_UNF_BIT),
                                     PWR_MASK);
        state_next.soft_reset = (ovf_set | unf_set) & state_reg.ctrl[CTRL_STK_RST_BIT];

        if (core_sleep) begin
            if (state_reg.ctrl[CTRL_IDLE_SEL_BIT]) begin
                state_next.idle = 1'b1;
            end else begin
                state_next.asleep = 1'b1;
            end
        end
        // wake does not look at the global enable; idle select stays as written
        wake_event = ext_edge | (|tmr_set);
        if (wake_event && (state_reg.idle || state_reg.asleep)) begin
            state_next.idle   = 1'b0;
            state_next.asleep = 1'b0;
            if (state_reg.idle && state_reg.ctrl[CTRL_ROI_BIT] && state_reg.ctrl[CTRL_DOZE_BIT]) begin
                state_next.ctrl[CTRL_DOZE_BIT] = 1'b0;
            end
        end

        // only bits that were actually returned by the read are cleared
        ev_set = ((8'(ext_edge) << EV_EXT_BIT) | (8'(|tmr_set) << EV_TMR_BIT)
               | (8'(ovf_set) << EV_OVF_BIT) | (8'(unf_set) << EV_UNF_BIT)
               | (8'(entry) << EV_ENTRY_BIT));
        ev_clear = (rd_hit && avs_address == OFS_IRQ_STATUS) ? state_reg.rdata[7:0] : 8'h00;
        state_next.ev  = ((state_reg.ev & ~ev_clear) | ev_set) & EV_MASK;
        state_next.irq = |(state_next.ev & state_next.mask);

        // read data captured on the request edge, presented while waitrequest is low
        if ((avs_read | avs_write) && !state_reg.ack) begin
            unique case (avs_address)
                OFS_CTRL:        state_next.rdata = 32'(state_reg.ctrl);
                OFS_PERIPH_FLG0: state_next.rdata = 32'(state_reg.pflags0);
                OFS_PWR_STATUS:  state_next.rdata = 32'(state_reg.pwr);
                OFS_IRQ_STATUS:  state_next.rdata = 32'(state_reg.ev);
                OFS_TMR_FLG4:    state_next.rdata = 32'(state_reg.tflags);
                OFS_IRQ_MASK:    state_next.rdata = 32'(state_reg.mask);
                OFS_CORE_STATE:  state_next.rdata = 32'({state_reg.sp, state_reg.asleep,
                                                         state_reg.idle, state_reg.in_isr});
                OFS_SHD_W:       state_next.rdata = 32'(state_reg.shadow.w);
                OFS_SHD_STATUS:  state_next.rdata = 32'(state_reg.shadow.status);
                OFS_SHD_BSR:     state_next.rdata = 32'(state_reg.shadow.bank_selector);
                OFS_SHD_FSR0:    state_next.rdata = 32'(state_reg.shadow.fsr0);
                OFS_SHD_FSR1:    state_next.rdata = 32'(state_reg.shadow.fsr1);
                OFS_SHD_PC_HIGH_LATCH:  state_next.rdata = 32'(state_reg.shadow.pc_high_latch);
                default:         state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg         <= '0;
            state_reg.waitreq <= 1'b1;
            state_reg.ctrl    <= CTRL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata    = state_reg.rdata;
    assign avs_waitrequest = state_reg.waitreq;
    assign irq             = state_reg.irq;
    assign vector_go       = state_reg.vector_go;
    assign restore_go      = state_reg.restore_go;
    assign restore_ctx     = state_reg.shadow;
    assign pop_pc          = state_reg.pop_pc;
    assign soft_reset      = state_reg.soft_reset;
    assign idle_active     = state_reg.idle;
    assign sleep_active    = state_reg.asleep;
    assign doze_active     = state_reg.ctrl[CTRL_DOZE_BIT];

endmodule

// ### tb_top.sv
module tb_top
    import ifc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam ifc_ctx_t CTX_A = 64'h3c1f_0b12_3456_780e;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        ext_int_pin = 1'b0;
    logic [2:0]  cmd = 3'h0;
    ifc_tmr_ev_t tmr_ev = '0;
    logic [31:0] avs_readdata, rv;
    logic        avs_waitrequest, irq, core_boundary, core_push, core_pop, core_retfie, core_sleep;
    logic        vector_go, restore_go, soft_reset, idle_active, sleep_active, doze_active;
    logic [14:0] core_ret_pc, core_push_pc, pop_pc;
    ifc_ctx_t    core_ctx, restore_ctx;
    int          fails = 0;
    int          checks = 0;
    int          nv = 0;
    int          nr = 0;
    int          ns = 0;
    always #50 clk = ~clk;
    // one-cycle pulses are tallied so scenarios can judge them later
    always @(posedge clk) begin
        if (vector_go === 1'b1) nv++;
        if (restore_go === 1'b1) nr++;
        if (soft_reset === 1'b1) ns++;
    end
    ifc_top ifc_top_i (
        .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .irq, .ext_int_pin, .tmr_ev, .core_boundary, .core_ret_pc, .core_ctx,
        .core_push, .core_push_pc, .core_pop, .core_retfie, .core_sleep, .vector_go,
        .restore_go, .restore_ctx, .pop_pc, .soft_reset, .idle_active, .sleep_active, .doze_active
    );
    ifc_core_model #(.CTX(CTX_A)) ifc_core_model_i (
        .clk, .rst, .cmd, .vector_go, .restore_go, .restore_ctx, .core_boundary, .core_ret_pc,
        .core_ctx, .core_push, .core_push_pc, .core_pop, .core_retfie, .core_sleep
    );
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // waits for the answer however long it takes; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [11:0] a, input logic [63:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, {32'h0, rv});
    endtask
    task automatic tpulse(input ifc_tmr_ev_t e);
        @(posedge clk);
        tmr_ev <= e;
        @(posedge clk);
        tmr_ev.odd_ovf <= 3'h0;
        tmr_ev.even_match <= 3'h0;
        tmr_ev.even_post_ovf <= 3'h0;
    endtask
    task automatic cpulse(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 3'h0;
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic t_timers();
        ifc_tmr_ev_t e;
        rchk("tflags", OFS_TMR_FLG4, 64'h0);
        bus(1'b1, OFS_TMR_FLG4, 32'hff);
        rchk("tflags", OFS_TMR_FLG4, 64'h3f);
        bus(1'b1, OFS_TMR_FLG4, 32'h0);
        rchk("unmapped", 12'h7fc, 64'h0);
        for (int i = 0; i < 6; i++) begin
            e = '0;
            e.even_1to1 = 3'h7;
            if (i % 2 == 0) e.odd_ovf[i / 2] = 1'b1;
            else e.even_match[i / 2] = 1'b1;
            tpulse(e);
            rchk("tflags", OFS_TMR_FLG4, (64'h1 << (i + 1)) - 64'h1);
        end
        bus(1'b1, OFS_TMR_FLG4, 32'h0);
        e = '0;
        e.even_match[0] = 1'b1;
        tpulse(e);
        rchk("tflags", OFS_TMR_FLG4, 64'h0);
        e = '0;
        e.even_post_ovf[0] = 1'b1;
        tpulse(e);
        rchk("tflags", OFS_TMR_FLG4, 64'h2);
        // the set lands on the very edge that the clearing write takes effect
        fork
            bus(1'b1, OFS_TMR_FLG4, 32'h0);
            begin
                repeat (2) @(posedge clk);
                tmr_ev.odd_ovf[1] <= 1'b1;
                @(posedge clk);
                tmr_ev.odd_ovf[1] <= 1'b0;
            end
        join
        rchk("tflags", OFS_TMR_FLG4, 64'h4);
    endtask
    task automatic t_irq();
        ifc_tmr_ev_t e;
        e = '0;
        e.odd_ovf[0] = 1'b1;
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'h2);
        tpulse(e);
        repeat (2) @(posedge clk);
        chk("irq", 64'h1, 64'(irq));
        rchk("irq_status", OFS_IRQ_STATUS, 64'h2);
        repeat (2) @(posedge clk);
        chk("irq", 64'h0, 64'(irq));
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        tpulse(e);
        repeat (2) @(posedge clk);
        chk("irq", 64'h0, 64'(irq));
    endtask
    task automatic t_entry();
        @(posedge clk);
        ext_int_pin <= 1'b1;
        repeat (8) @(posedge clk);
        rchk("ext_flag", OFS_PERIPH_FLG0, 64'h1);
        chk("vectors", 64'h0, 64'(nv));
        bus(1'b1, OFS_CTRL, 32'h43);
        repeat (4) @(posedge clk);
        chk("vectors", 64'h1, 64'(nv));
        rchk("shd_status", OFS_SHD_STATUS, 64'h07);
        rchk("shd_w", OFS_SHD_W, 64'h3c);
        bus(1'b1, OFS_SHD_W, 32'h5a);
        bus(1'b1, OFS_PERIPH_FLG0, 32'h0);
        cpulse(3'h1);
        repeat (2) @(posedge clk);
        chk("restores", 64'h1, 64'(nr));
        chk("pop_pc", 64'h1234, 64'(pop_pc));
        chk("ctx", 64'h5a1f_0b12_3456_780e, core_ctx);
    endtask
    task automatic t_stack();
        bus(1'b1, OFS_CTRL, 32'h60);
        repeat (16) cpulse(3'h2);
        chk("sresets", 64'h0, 64'(ns));
        cpulse(3'h2);
        repeat (2) @(posedge clk);
        chk("sresets", 64'h1, 64'(ns));
        rchk("pwr", OFS_PWR_STATUS, 64'h80);
        repeat (16) cpulse(3'h3);
        @(posedge clk);
        chk("pop_pc", 64'h4abc, 64'(pop_pc));
        cpulse(3'h3);
        repeat (2) @(posedge clk);
        chk("pop_pc", 64'h0, 64'(pop_pc));
        chk("sresets", 64'h2, 64'(ns));
        rchk("pwr", OFS_PWR_STATUS, 64'hc0);
    endtask
    task automatic t_idle();
        ifc_tmr_ev_t e;
        e = '0;
        e.odd_ovf[2] = 1'b1;
        bus(1'b1, OFS_CTRL, 32'h1c);
        cpulse(3'h4);
        @(posedge clk);
        chk("idle", 64'h1, 64'(idle_active));
        chk("doze", 64'h1, 64'(doze_active));
        tpulse(e);
        repeat (3) @(posedge clk);
        chk("idle", 64'h0, 64'(idle_active));
        chk("doze", 64'h0, 64'(doze_active));
        rchk("ctrl", OFS_CTRL, 64'h0c);
        cpulse(3'h4);
        @(posedge clk);
        chk("idle", 64'h1, 64'(idle_active));
        // without recover-on-irq the wake leaves doze alone
        bus(1'b1, OFS_CTRL, 32'h14);
        tpulse(e);
        repeat (2) @(posedge clk);
        chk("idle", 64'h0, 64'(idle_active));
        chk("doze", 64'h1, 64'(doze_active));
        bus(1'b1, OFS_CTRL, 32'h00);
        cpulse(3'h4);
        @(posedge clk);
        chk("sleep", 64'h1, 64'(sleep_active));
        chk("idle", 64'h0, 64'(idle_active));
        tpulse(e);
        repeat (2) @(posedge clk);
        chk("sleep", 64'h0, 64'(sleep_active));
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_timers();
        t_irq();
        t_entry();
        t_stack();
        t_idle();
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        $display("BAD watchdog expected done seen timeout");
        final_report();
    end
endmodule
